// [hdl/pec_top.sv]
// Performance event counters with select registers, monitor pins and overflow request
`timescale 1ns/10ps
`include "pec_defines.svh"
module pec_top
	import pec_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register access
	input wire logic msr_rd_en,
	input wire logic msr_wr_en,
	input wire logic [31:0] msr_addr,
	input wire logic [63:0] msr_wdata,
	output logic [63:0] msr_rdata,
	output logic msr_ack,
	output logic msr_fault,
	// Capability query
	output logic [31:0] cap_eax,
	output logic [31:0] cap_ebx,
	// Core status
	input wire logic [1:0] priv_level,
	input wire logic non_c0_state,
	input wire logic halt_state,
	input wire logic stop_clock_input,
	input wire logic thermal_throttle_mode,
	input wire logic freq_switch,
	input wire logic vm_exit,
	// Event sources
	input wire logic ref_clk_tick,
	input wire logic [2:0] inst_retired_cnt,
	input wire logic [1:0] br_retired_cnt,
	input wire logic [1:0] br_mispred_cnt,
	input wire logic llc_req,
	input wire logic llc_req_prefetch,
	input wire logic llc_req_miss,
	// Outputs to pins and interrupt controller
	output logic [`PEC_NUM_CTR-1:0] monitor_pin,
	output logic lic_irq
);
	localparam int N = `PEC_NUM_CTR;

	// Returns {hit, index} of an address inside a block of N registers
	function automatic logic [1:0] msr_dec(input logic [31:0] addr, input logic [31:0] base);
		logic [31:0] diff;
		diff = addr - base;
		msr_dec = {(addr >= base) && (diff < 32'(N)), diff[0]};
	endfunction

	// Count of the selected event this cycle, zero for unsupported codes
	function automatic logic [3:0] evt_count(input logic [31:0] sel, input pec_src_s s);
		logic [3:0] r;
		r = 4'h0;
		unique case ({sel[7:0], sel[15:8]})
			{`PEC_EV_CYC, `PEC_UM_NONE}: r = s.core_cyc;
			{`PEC_EV_CYC, `PEC_UM_REF}: r = s.ref_cyc;
			{`PEC_EV_INST, `PEC_UM_NONE}: r = s.inst;
			{`PEC_EV_LLC, `PEC_UM_LLCREF}: r = s.llc_ref;
			{`PEC_EV_LLC, `PEC_UM_LLCMISS}: r = s.llc_miss;
			{`PEC_EV_BR, `PEC_UM_NONE}: r = s.br;
			{`PEC_EV_BRMS, `PEC_UM_NONE}: r = s.brms;
			default: r = 4'h0;
		endcase
		evt_count = r;
	endfunction

	// Reset release
	logic [1:0] rst_sync_r;
	logic rst_n_sync;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	assign rst_n_sync = rst_sync_r[1];

	// Event source conditioning
	pec_src_s src;
	logic core_run;

	always_comb
	begin
		core_run = !(non_c0_state || halt_state || stop_clock_input ||
			thermal_throttle_mode || freq_switch);
		src.core_cyc = {3'h0, core_run};
		src.ref_cyc = {3'h0, core_run && ref_clk_tick};
		src.inst = vm_exit ? 4'h0 : {1'b0, inst_retired_cnt};
		src.llc_ref = {3'h0, llc_req && !llc_req_prefetch};
		src.llc_miss = {3'h0, llc_req && llc_req_miss && !llc_req_prefetch};
		src.br = {2'h0, br_retired_cnt};
		src.brms = {2'h0, br_mispred_cnt};
	end

	// Register access decode
	logic [1:0] ctr_dec;
	logic [1:0] sel_dec;
	logic hit_any;

	always_comb
	begin
		ctr_dec = msr_dec(msr_addr, `PEC_CTR_BASE);
		sel_dec = msr_dec(msr_addr, `PEC_SEL_BASE);
		hit_any = ctr_dec[1] || sel_dec[1];
	end

	// Select registers
	logic [31:0] sel_r [N];
	logic [31:0] sel_nxt [N];

	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			sel_nxt[i] = sel_r[i];
			if (msr_wr_en && sel_dec[1] && sel_dec[0] == 1'(i))
				sel_nxt[i] = msr_wdata[31:0] & `PEC_SEL_MASK;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			for (int i = 0; i < N; i++)
				sel_r[i] <= `PEC_SEL_RST;
		end
		else
		begin
			for (int i = 0; i < N; i++)
				sel_r[i] <= sel_nxt[i];
		end
	end

	// Counter units
	logic [`PEC_CTR_W-1:0] cnt_v [N];
	logic [N-1:0] ovf_v;
	logic [N-1:0] hit_v;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : gen_ctr
			pec_ctr_if ctr_if ();
			assign ctr_if.sel = sel_r[g];
			assign ctr_if.evt_cnt = evt_count(sel_r[g], src);
			assign ctr_if.priv_pl = priv_level;
			assign ctr_if.wr_en = msr_wr_en && ctr_dec[1] && ctr_dec[0] == 1'(g);
			assign ctr_if.wr_data = msr_wdata[31:0];
			assign cnt_v[g] = ctr_if.count;
			assign ovf_v[g] = ctr_if.ovf;
			assign hit_v[g] = ctr_if.hit;
			pec_ctr_unit u_ctr (
				.clk(sys_clk),
				.rst_n(rst_n_sync),
				.ctr(ctr_if)
			);
		end
	endgenerate

	// Read path
	logic [63:0] rdata_r;
	logic [63:0] rdata_nxt;
	logic ack_r;
	logic ack_nxt;
	logic fault_r;
	logic fault_nxt;

	always_comb
	begin
		rdata_nxt = rdata_r;
		ack_nxt = msr_rd_en || msr_wr_en;
		fault_nxt = (msr_rd_en || msr_wr_en) && !hit_any;
		if (msr_rd_en)
		begin
			if (ctr_dec[1])
				rdata_nxt = {24'h00_0000, cnt_v[ctr_dec[0]]};
			else if (sel_dec[1])
				rdata_nxt = {32'h0000_0000, sel_r[sel_dec[0]]};
			else
				rdata_nxt = 64'h0000_0000_0000_0000;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			rdata_r <= 64'h0000_0000_0000_0000;
			ack_r <= 1'b0;
			fault_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
			fault_r <= fault_nxt;
		end
	end

	assign msr_rdata = rdata_r;
	assign msr_ack = ack_r;
	assign msr_fault = fault_r;
	assign cap_eax = `PEC_CAP_EAX;
	assign cap_ebx = `PEC_CAP_EBX;

	// Bus clock divider
	logic [1:0] div_r;
	logic [1:0] div_nxt;
	logic bus_tick;

	always_comb
	begin
		bus_tick = div_r == `PEC_BUS_DIV_MAX;
		div_nxt = bus_tick ? 2'h0 : div_r + 2'h1;
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			div_r <= 2'h0;
		else
			div_r <= div_nxt;
	end

	// Monitor pin pulse generators
	pec_pin_e pin_st_r [N];
	pec_pin_e pin_st_nxt [N];
	logic [N-1:0] pend_r;
	logic [N-1:0] pend_nxt;
	logic [N-1:0] pin_req;

	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			pin_req[i] = sel_r[i][`PEC_F_PC] ? hit_v[i] : ovf_v[i];
			pin_st_nxt[i] = pin_st_r[i];
			pend_nxt[i] = pend_r[i];
			unique case (pin_st_r[i])
				PIN_IDLE:
					if (pend_r[i] && bus_tick)
					begin
						pin_st_nxt[i] = PIN_HIGH;
						pend_nxt[i] = 1'b0;
					end
				PIN_HIGH:
					if (bus_tick)
						pin_st_nxt[i] = PIN_IDLE;
				default:
					pin_st_nxt[i] = PIN_IDLE;
			endcase
			if (pin_req[i])
				pend_nxt[i] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			for (int i = 0; i < N; i++)
				pin_st_r[i] <= PIN_IDLE;
			pend_r <= '0;
		end
		else
		begin
			for (int i = 0; i < N; i++)
				pin_st_r[i] <= pin_st_nxt[i];
			pend_r <= pend_nxt;
		end
	end

	always_comb
	begin
		for (int i = 0; i < N; i++)
			monitor_pin[i] = pin_st_r[i] == PIN_HIGH;
	end

	// Overflow interrupt request
	logic irq_r;
	logic irq_nxt;
	logic [N-1:0] int_en_v;

	always_comb
	begin
		for (int i = 0; i < N; i++)
			int_en_v[i] = sel_r[i][`PEC_F_INT];
		irq_nxt = |(ovf_v & int_en_v);
	end

	always_ff @(posedge sys_clk or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			irq_r <= 1'b0;
		else
			irq_r <= irq_nxt;
	end

	assign lic_irq = irq_r;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n_sync);

	sequence s_pin_pulse0;
		monitor_pin[0] [*4] ##1 !monitor_pin[0];
	endsequence

	sequence s_pin_pulse1;
		monitor_pin[1] [*4] ##1 !monitor_pin[1];
	endsequence

	AST_PIN_PULSE0: assert property ($rose(monitor_pin[0]) |-> s_pin_pulse0)
		else $error("monitor pin 0 pulse not one bus clock");
	AST_PIN_PULSE1: assert property ($rose(monitor_pin[1]) |-> s_pin_pulse1)
		else $error("monitor pin 1 pulse not one bus clock");
	AST_PIN_FOLLOWS: assert property (pin_req[0] && pin_st_r[0] == PIN_IDLE && !pend_r[0]
		|-> ##[1:5] monitor_pin[0])
		else $error("monitor pin 0 missed a request");
	AST_IRQ: assert property (ovf_v[0] && sel_r[0][`PEC_F_INT] |=> lic_irq)
		else $error("overflow did not raise interrupt");
	AST_NO_IRQ: assert property (!(|(ovf_v & int_en_v)) |=> !lic_irq)
		else $error("interrupt without enabled overflow");
	AST_CORE_GATE: assert property (halt_state || stop_clock_input || non_c0_state
		|-> src.core_cyc == 4'h0 && src.ref_cyc == 4'h0)
		else $error("core cycle event ran while core stopped");
	AST_PREFETCH: assert property (llc_req_prefetch |-> src.llc_ref == 4'h0 && src.llc_miss == 4'h0)
		else $error("prefetch fill counted as cache event");
	AST_FAULT: assert property ((msr_rd_en || msr_wr_en) && !hit_any |=> msr_fault && msr_ack)
		else $error("unmapped access not faulted");
	AST_SEL_WRITE: assert property (msr_wr_en && sel_dec == 2'b10
		|=> sel_r[0] == ($past(msr_wdata[31:0]) & `PEC_SEL_MASK))
		else $error("select register write lost");
endmodule

// [hdl/pec_defines.svh]
// Constants for the performance event counter block
// Behaviour
// - Event counters sit at consecutive register addresses from 0C1H; count reported by capability query.
// - Event select registers sit at consecutive addresses from 186H, paired by index.
// - Counter writes load only the low 32 bits; reads return the full width.
// - Select bits 7:0 choose the event unit feeding the paired counter.
// - Select bits 15:8 qualify the condition the chosen event unit detects.
// - Bit 16 set counts the event at privilege levels one to three.
// - Bit 17 set counts the event at privilege level zero; combinable with bit 16.
// - Bit 18 set counts only rising transitions of the qualified condition.
// - Bit 19 set pulses the monitor pin per counted event, else on overflow; code requests one pulse per incrementing cycle, merged while pending.
// - A monitor pin pulse is high for exactly one bus clock, then low.
// - Bit 20 set raises an interrupt request on each counter overflow.
// - Bit 22 set lets the counter increment; clear holds it.
// - Bit 23 set inverts the threshold comparison result.
// - Nonzero threshold: add one when the cycle's event count reaches the threshold.
// - Zero threshold: add the full per-cycle event count.
// - Supported encodings: 3C/00, C0/00, 3C/01, 2E/4F, 2E/41, C4/00, C5/00.
// - Capability query gives vector length in bits 31:24; set vector bits mean unavailable.
// - Core cycles stop in sleep, halt, stop clock, throttling and frequency switching.
// - Reference cycles count fixed reference ticks while the core clock runs.
// - Instructions retired count last micro-op retirements and stop during VM exits.
// - Cache reference and miss events exclude hardware prefetch fills.
`ifndef PEC_DEFINES_SVH
`define PEC_DEFINES_SVH
`define PEC_NUM_CTR 2
`define PEC_CTR_W 40
`define PEC_WR_W 32
`define PEC_CTR_BASE 32'h0000_00C1
`define PEC_SEL_BASE 32'h0000_0186
`define PEC_F_USR 16
`define PEC_F_OS 17
`define PEC_F_EDGE 18
`define PEC_F_PC 19
`define PEC_F_INT 20
`define PEC_F_EN 22
`define PEC_F_INV 23
`define PEC_SEL_MASK 32'hFFDF_FFFF
`define PEC_SEL_RST 32'h0000_0000
`define PEC_EV_CYC 8'h3C
`define PEC_EV_INST 8'hC0
`define PEC_EV_LLC 8'h2E
`define PEC_EV_BR 8'hC4
`define PEC_EV_BRMS 8'hC5
`define PEC_UM_NONE 8'h00
`define PEC_UM_REF 8'h01
`define PEC_UM_LLCREF 8'h4F
`define PEC_UM_LLCMISS 8'h41
// Version 1, 2 counters, 40-bit width, 7-bit event vector
`define PEC_CAP_EAX 32'h0728_0201
`define PEC_CAP_EBX 32'h0000_0000
`define PEC_BUS_DIV_MAX 2'h3
`endif

// [hdl/pec_pkg.sv]
// Types for the performance event counter block
package pec_pkg;
	typedef enum logic [1:0] {
		PIN_IDLE = 2'b01,
		PIN_HIGH = 2'b10
	} pec_pin_e;
	typedef struct packed {
		logic [3:0] core_cyc;
		logic [3:0] ref_cyc;
		logic [3:0] inst;
		logic [3:0] llc_ref;
		logic [3:0] llc_miss;
		logic [3:0] br;
		logic [3:0] brms;
	} pec_src_s;
endpackage

// [hdl/pec_ctr_if.sv]
// Link between the control block and one counter unit
`timescale 1ns/10ps
interface pec_ctr_if;
	logic [31:0] sel;
	logic [3:0] evt_cnt;
	logic [1:0] priv_pl;
	logic wr_en;
	logic [31:0] wr_data;
	logic [39:0] count;
	logic ovf;
	logic hit;
	modport ctl (output sel, evt_cnt, priv_pl, wr_en, wr_data, input count, ovf, hit);
	modport unit (input sel, evt_cnt, priv_pl, wr_en, wr_data, output count, ovf, hit);
endinterface

// [hdl/pec_ctr_unit.sv]
// One qualified event counter with threshold, edge and privilege filtering
`timescale 1ns/10ps
`include "pec_defines.svh"
module pec_ctr_unit
	import pec_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control link
	pec_ctr_if.unit ctr
);
	logic [`PEC_CTR_W-1:0] count_r;
	logic [`PEC_CTR_W-1:0] count_nxt;
	logic cond_prev_r;
	logic cond_prev_nxt;
	logic priv_ok;
	logic cmp;
	logic cond;
	logic [7:0] q_cnt;
	logic [7:0] inc;
	logic [`PEC_CTR_W:0] sum;

	always_comb
	begin
		priv_ok = (ctr.sel[`PEC_F_USR] && ctr.priv_pl != 2'h0) ||
			(ctr.sel[`PEC_F_OS] && ctr.priv_pl == 2'h0);
		q_cnt = priv_ok ? {4'h0, ctr.evt_cnt} : 8'h00;
		cmp = (q_cnt >= ctr.sel[31:24]) ^ ctr.sel[`PEC_F_INV];
		// Privilege gates the inverted compare as well
		cond = priv_ok && ((ctr.sel[31:24] != 8'h00) ? cmp : (q_cnt != 8'h00));
		if (ctr.sel[`PEC_F_EDGE])
			inc = {7'h00, cond && !cond_prev_r};
		else if (ctr.sel[31:24] != 8'h00)
			inc = {7'h00, cond};
		else
			inc = q_cnt;
		if (!ctr.sel[`PEC_F_EN])
			inc = 8'h00;
		sum = {1'b0, count_r} + {33'h0, inc};
		cond_prev_nxt = cond;
		if (ctr.wr_en)
			count_nxt = {8'h00, ctr.wr_data};
		else
			count_nxt = sum[`PEC_CTR_W-1:0];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_r <= 40'h00_0000_0000;
			cond_prev_r <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			cond_prev_r <= cond_prev_nxt;
		end
	end

	assign ctr.count = count_r;
	assign ctr.ovf = sum[`PEC_CTR_W] && !ctr.wr_en;
	assign ctr.hit = (inc != 8'h00) && !ctr.wr_en;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_WRITE_LOW32: assert property (ctr.wr_en |=> count_r == {8'h00, $past(ctr.wr_data)})
		else $error("counter write did not load low word");
	AST_DISABLED_HOLD: assert property (!ctr.sel[`PEC_F_EN] && !ctr.wr_en |=> $stable(count_r))
		else $error("disabled counter moved");
	AST_NO_PRIV: assert property (!ctr.sel[`PEC_F_USR] && !ctr.sel[`PEC_F_OS] && !ctr.wr_en
		|=> $stable(count_r))
		else $error("counter moved with no privilege level selected");
	AST_THRESH_STEP: assert property (ctr.sel[31:24] != 8'h00 && !ctr.wr_en && !ctr.ovf
		|=> count_r == $past(count_r) || count_r == $past(count_r) + 40'h1)
		else $error("threshold mode stepped by more than one");
	AST_EDGE_ONCE: assert property (ctr.sel[`PEC_F_EDGE] && cond_prev_r && !ctr.wr_en
		|=> $stable(count_r))
		else $error("edge mode counted a held condition");
	AST_WRAP: assert property (ctr.ovf |=> count_r < $past(count_r) && count_r < 40'h8)
		else $error("overflow did not wrap the counter");
endmodule

// [test/pec_src_model.sv]
// Far-side model of core status and event sources
`timescale 1ns/10ps
module pec_src_model (
	// Clock and control
	input wire logic clk,
	input wire logic ev_on,
	// Core status
	output logic [1:0] priv_level,
	output logic [4:0] stop_v,
	output logic vm_exit,
	// Event sources
	output logic ref_clk_tick,
	output logic [2:0] inst_cnt,
	output logic [1:0] br_cnt,
	output logic [1:0] brms_cnt,
	output logic [2:0] llc_v
);
	initial
	begin
		{priv_level, stop_v, vm_exit, ref_clk_tick, inst_cnt, br_cnt, brms_cnt, llc_v} = '0;
	end
	// Privilege wanders always; events only while enabled
	always @(negedge clk)
	begin
		priv_level <= 2'($urandom);
		if (ev_on)
		begin
			stop_v <= ($urandom % 6 == 0) ? 5'(1 << ($urandom % 5)) : 5'h00;
			vm_exit <= ($urandom % 5 == 0);
			ref_clk_tick <= 1'($urandom);
			inst_cnt <= 3'($urandom);
			br_cnt <= 2'($urandom);
			brms_cnt <= 2'($urandom);
			llc_v <= 3'($urandom);
		end
		else
			{stop_v, vm_exit, ref_clk_tick, inst_cnt, br_cnt, brms_cnt, llc_v} <= '0;
	end
endmodule

// [test/pec_top_test.sv]
// Self-checking bench for the performance event counters
`timescale 1ns/10ps
`include "pec_defines.svh"
module pec_top_test;
	import pec_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic ev_on = 1'b0;
	logic [31:0] addr = 32'h0000_0000;
	logic [63:0] wdata = 64'h0;
	logic [63:0] rdata;
	logic ack, fault, irq, vmx, rtick;
	logic [31:0] cap_eax, cap_ebx, s;
	logic [1:0] priv, brc, bmc, pin;
	logic [4:0] stp;
	logic [2:0] inst, last_level_cache;
	logic [39:0] exp_c[2];
	logic [39:0] inc, st;
	logic [31:0] sel_sh[2] = '{32'h0, 32'h0};
	logic prev[2] = '{1'b0, 1'b0};
	logic [15:0] enc[8] = '{16'h3C00, 16'hC000, 16'h3C01, 16'h2E4F, 16'h2E41, 16'hC400, 16'hC500, 16'h5500};
	int err_total = 0;
	int check_count = 0;
	int pulses[2] = '{0, 0};
	int hi_len[2] = '{0, 0};
	int irq_seen = 0;
	int i, p0;
	always #2.5 sys_clk = ~sys_clk;
	pec_top pec_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .msr_rd_en(rd_en), .msr_wr_en(wr_en),
		.msr_addr(addr), .msr_wdata(wdata), .msr_rdata(rdata), .msr_ack(ack), .msr_fault(fault),
		.cap_eax(cap_eax), .cap_ebx(cap_ebx), .priv_level(priv), .non_c0_state(stp[4]),
		.halt_state(stp[3]), .stop_clock_input(stp[2]), .thermal_throttle_mode(stp[1]),
		.freq_switch(stp[0]), .vm_exit(vmx), .ref_clk_tick(rtick), .inst_retired_cnt(inst),
		.br_retired_cnt(brc), .br_mispred_cnt(bmc), .llc_req(last_level_cache[0]), .llc_req_prefetch(last_level_cache[1]),
		.llc_req_miss(last_level_cache[2]), .monitor_pin(pin), .lic_irq(irq));
	pec_src_model pec_src_model_i (.clk(sys_clk), .ev_on(ev_on), .priv_level(priv), .stop_v(stp),
		.vm_exit(vmx), .ref_clk_tick(rtick), .inst_cnt(inst), .br_cnt(brc), .brms_cnt(bmc), .llc_v(last_level_cache));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One access; answer sampled in the cycle after the request is taken
	task automatic bus(input logic wr, input logic [31:0] a, input logic [63:0] d, input logic flt);
		@(negedge sys_clk);
		rd_en = !wr;
		wr_en = wr;
		addr = a;
		wdata = d;
		@(negedge sys_clk);
		rd_en = 1'b0;
		wr_en = 1'b0;
		chk({62'h0, ack, fault}, {62'h0, 1'b1, flt});
	endtask
	// Per-cycle increment for one counter from its select value
	function automatic logic [39:0] step(input logic [31:0] v, input int k);
		logic [3:0] n;
		logic cond;
		logic ok;
		case ({v[7:0], v[15:8]})
			16'h3C00: n = 4'(stp == 5'h00);
			16'h3C01: n = 4'(stp == 5'h00 && rtick);
			16'hC000: n = vmx ? 4'h0 : 4'(inst);
			16'h2E4F: n = 4'(last_level_cache[0] && !last_level_cache[1]);
			16'h2E41: n = 4'(last_level_cache[0] && !last_level_cache[1] && last_level_cache[2]);
			16'hC400: n = 4'(brc);
			16'hC500: n = 4'(bmc);
			default: n = 4'h0;
		endcase
		ok = (v[`PEC_F_USR] && priv != 2'h0) || (v[`PEC_F_OS] && priv == 2'h0);
		if (!ok)
			n = 4'h0;
		cond = ok && ((v[31:24] == 8'h00) ? (n != 4'h0) : (({4'h0, n} >= v[31:24]) ^ v[`PEC_F_INV]));
		step = v[`PEC_F_EDGE] ? 40'(cond && !prev[k]) : (v[31:24] == 8'h00 ? 40'(n) : 40'(cond));
		prev[k] = cond;
	endfunction
	always @(posedge sys_clk)
	begin
		for (int k = 0; k < 2; k++)
		begin
			inc = step(sel_sh[k], k);
			if (wr_en && addr == `PEC_CTR_BASE + k)
				exp_c[k] = 40'(wdata[31:0]);
			else if (sel_sh[k][`PEC_F_EN])
				exp_c[k] += inc;
			if (wr_en && addr == `PEC_SEL_BASE + k)
				sel_sh[k] = wdata[31:0] & `PEC_SEL_MASK;
			if (pin[k])
				hi_len[k]++;
			else if (hi_len[k] != 0)
			begin
				chk(64'(hi_len[k]), 64'h4);
				pulses[k]++;
				hi_len[k] = 0;
			end
		end
		if (irq)
			irq_seen++;
	end
	initial
	begin
		#100000;
		err_total++;
		conclude();
	end
	initial
	begin
		void'($urandom(69518));
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(64'(cap_eax), {32'h0, 8'h07, 8'h28, 8'h02, 8'h01});
		chk(64'(cap_ebx), 64'h0);
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b0, `PEC_SEL_BASE + k, 64'h0, 1'b0);
			chk(rdata, 64'h0);
			bus(1'b0, `PEC_CTR_BASE + k, 64'h0, 1'b0);
			chk(rdata, 64'h0);
			bus(1'b1, `PEC_CTR_BASE + k, {$urandom, $urandom}, 1'b0);
			bus(1'b0, `PEC_CTR_BASE + k, 64'h0, 1'b0);
			chk(rdata, {24'h0, exp_c[k]});
			s = $urandom;
			bus(1'b1, `PEC_SEL_BASE + k, {32'hFFFF_FFFF, s}, 1'b0);
			bus(1'b0, `PEC_SEL_BASE + k, 64'h0, 1'b0);
			chk(rdata, {32'h0, s & 32'hFFDF_FFFF});
			bus(1'b1, `PEC_SEL_BASE + k, 64'h0, 1'b0);
		end
		foreach (enc[j])
		begin
			bus(1'b0, 32'h0000_00C3 + 32'(j), 64'h0, 1'b1);
			chk(rdata, 64'h0);
			bus(1'b1, 32'h0000_0188 + 32'(j), 64'h1, 1'b1);
		end
		$display("test register access done");
		for (int t = 0; t < 32; t++)
		begin
			i = t % 2;
			s = {8'($urandom % 4), 8'($urandom), enc[t % 8]};
			s[22:21] = 2'b10;
			bus(1'b1, `PEC_CTR_BASE + i, {32'h0, $urandom}, 1'b0);
			st = exp_c[i];
			p0 = pulses[i];
			bus(1'b1, `PEC_SEL_BASE + i, {32'h0, s}, 1'b0);
			ev_on = 1'b1;
			repeat (40) @(negedge sys_clk);
			ev_on = 1'b0;
			repeat (3) @(negedge sys_clk);
			bus(1'b1, `PEC_SEL_BASE + i, {32'h0, s & 32'hFFBF_FFFF}, 1'b0);
			repeat (16) @(negedge sys_clk);
			bus(1'b0, `PEC_CTR_BASE + i, 64'h0, 1'b0);
			chk(rdata, {24'h0, exp_c[i]});
			chk(64'(pulses[i] != p0), 64'(s[`PEC_F_PC] && exp_c[i] != st));
			bus(1'b1, `PEC_SEL_BASE + i, 64'h0, 1'b0);
			$display("test count %0d select %h done", t, s);
		end
		chk(64'(irq_seen), 64'h0);
		conclude();
	end
endmodule
